// ===== inc/tic_pkg.sv
// Shared constants, register map and carrier types of the input capture block.
package tic_pkg;
  localparam int NUM_UNITS = 3;
  localparam int NUM_TIMERS = 3;
  localparam int TMR_W = 16;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // Register byte offsets.
  localparam logic [7:0] REG_MODE = 8'h00;
  localparam logic [7:0] REG_TSEL = 8'h04;
  localparam logic [7:0] REG_PINSEL = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_CLEAR = 8'h10;
  localparam logic [7:0] REG_ENABLE = 8'h14;
  localparam logic [7:0] REG_CAP0 = 8'h20;
  // Field layout.
  localparam int MODE_W = 4;
  localparam int TSEL_W = 2;
  localparam int CAP_LOW_LSB = 0;
  localparam int CAP_HIGH_LSB = 8;
  // Capture mode codes and prescaler terminal counts.
  localparam logic [3:0] MODE_FALL = 4'h4;
  localparam logic [3:0] MODE_RISE = 4'h5;
  localparam logic [3:0] MODE_RISE4 = 4'h6;
  localparam logic [3:0] MODE_RISE16 = 4'h7;
  localparam logic [3:0] PRESCALE_4 = 4'h3;
  localparam logic [3:0] PRESCALE_16 = 4'hF;
  // Reset values and divider terminal count.
  localparam logic [3:0] MODE_RST = 4'h0;
  localparam logic [1:0] TSEL_RST = 2'h0;
  localparam logic [1:0] PINSEL_RST = 2'h1;
  localparam logic [1:0] INSTR_DIV_LAST = 2'h3;

  typedef struct packed {
    logic [3:0] mode;
    logic mode_wr;
    logic [1:0] tsel;
  } tic_unit_cfg_t;

  typedef struct packed {
    logic capture;
    logic [15:0] value;
  } tic_unit_evt_t;
endpackage

// ===== verilog/tic_divider.sv
// Instruction clock enable: one pulse every fourth bus clock.
`timescale 1ns/1ps
module tic_divider (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Enable out
  output logic instr_en
);
  typedef struct packed {
    logic [1:0] cnt;
    logic en;
  } tic_div_state_t;

  tic_div_state_t st;
  tic_div_state_t next_st;

  always_comb begin
    next_st = st;
    next_st.cnt = st.cnt + 2'h1;
    next_st.en = (st.cnt == tic_pkg::INSTR_DIV_LAST);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign instr_en = st.en;

  property p_div_period;
    @(posedge pclk) disable iff (!presetn)
      instr_en |=> !instr_en ##1 !instr_en ##1 !instr_en ##1 instr_en;
  endproperty
  a_div_period: assert property (p_div_period)
    else $error("instruction enable not periodic by four");
endmodule

// ===== verilog/tic_unit.sv
// One capture unit: pin synchroniser, edge detect, prescale and capture latch.
`timescale 1ns/1ps
module tic_unit (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic instr_en,
  // Configuration, pin and timer counts
  input wire tic_pkg::tic_unit_cfg_t cfg,
  input wire logic pin,
  input wire logic [47:0] timers,
  // Result
  output tic_pkg::tic_unit_evt_t evt
);
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic last;
    logic [3:0] pre;
    tic_pkg::tic_unit_evt_t evt;
  } tic_unit_state_t;

  tic_unit_state_t st;
  tic_unit_state_t next_st;
  logic rise;
  logic fall;
  logic [15:0] tmr_now;

  always_comb begin
    rise = st.sync2 && !st.last;
    fall = !st.sync2 && st.last;
    unique case (cfg.tsel)
      2'h1: tmr_now = timers[31:16];
      2'h2: tmr_now = timers[47:32];
      default: tmr_now = timers[15:0]; // see R1
    endcase
    next_st = st;
    next_st.evt.capture = 1'b0;
    next_st.sync1 = pin;
    next_st.sync2 = st.sync1; // see R13
    if (cfg.mode_wr) begin
      next_st.pre = 4'h0; // see R13
    end else if (instr_en) begin
      next_st.last = st.sync2;
      unique case (cfg.mode) // see R3
        tic_pkg::MODE_FALL: next_st.evt.capture = fall;
        tic_pkg::MODE_RISE: next_st.evt.capture = rise;
        tic_pkg::MODE_RISE4, tic_pkg::MODE_RISE16: begin
          if (rise) begin
            if (st.pre == ((cfg.mode == tic_pkg::MODE_RISE4) ? tic_pkg::PRESCALE_4
                                                              : tic_pkg::PRESCALE_16)) begin
              next_st.pre = 4'h0;
              next_st.evt.capture = 1'b1;
            end else begin
              next_st.pre = st.pre + 4'h1;
            end
          end
        end
        default: next_st.pre = 4'h0;
      endcase
      if (next_st.evt.capture) begin
        next_st.evt.value = tmr_now; // see R2, R6
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign evt = st.evt;

  property p_rise_cap;
    @(posedge pclk) disable iff (!presetn)
      (instr_en && !cfg.mode_wr && cfg.mode == tic_pkg::MODE_RISE && rise) |=> evt.capture;
  endproperty
  a_rise_cap: assert property (p_rise_cap) // see R3
    else $error("rising edge not captured");
  property p_fall_cap;
    @(posedge pclk) disable iff (!presetn)
      (instr_en && !cfg.mode_wr && cfg.mode == tic_pkg::MODE_FALL && fall) |=> evt.capture;
  endproperty
  a_fall_cap: assert property (p_fall_cap) // see R3
    else $error("falling edge not captured");
  property p_cap_value;
    @(posedge pclk) disable iff (!presetn)
      evt.capture |-> evt.value == $past(tmr_now);
  endproperty
  a_cap_value: assert property (p_cap_value) // see R2
    else $error("captured value differs from timer");
  property p_no_cap_off;
    @(posedge pclk) disable iff (!presetn)
      (cfg.mode == tic_pkg::MODE_RST) |=> !evt.capture;
  endproperty
  a_no_cap_off: assert property (p_no_cap_off) // see R3
    else $error("capture while mode is off");
endmodule

// ===== verilog/tic_capture.sv
// Input capture block top: APB registers, interrupt logic and three capture units.
//
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
// Notes on behaviour
// R1 - Each unit picks its own 16-bit timer through its timer select field.
// R2 - A qualifying pin event copies the whole 16-bit selected timer count.
// R3 - Mode field picks falling, rising, fourth rising or sixteenth rising edges.
// R4 - Each completed capture sets that unit's interrupt request flag.
// R5 - Software clears the flag; hardware never clears it itself.
// R6 - A new capture overwrites an unread value with no overrun indication.
// R7 - Software should set the pin direction to input for capture.
// R8 - With pin as output, a port write making an edge is captured.
// R9 - Units two and three choose between two pins; defaults one and zero.
// R10 - The selected timer must run in timer or synchronized counter mode.
// R11 - Mode change may flag falsely; software masks, then clears the flag.
// R12 - Capture timer runs from instruction clock or external source only.
// R13 - Pin synchronised before edge detect; mode write restarts the prescaler.
module tic_capture (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Timer counts, timer 0 in the low bits
  input wire logic [47:0] timer_count,
  // Capture pins: primary and alternate, with port output and direction
  input wire logic [2:0] pin_primary,
  input wire logic [2:0] pin_alternate,
  input wire logic [2:0] port_out,
  input wire logic [2:0] port_direction_bit,
  // Interrupt
  output logic irq
);
  localparam int N = tic_pkg::NUM_UNITS;

  typedef struct packed {
    logic [2:0][3:0] mode;
    logic [2:0] mode_wr;
    logic [2:0][1:0] tsel;
    logic [1:0] pinsel;
    logic [2:0] status;
    logic [2:0] enable;
    logic [2:0][15:0] value;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
  } tic_top_state_t;

  tic_top_state_t st;
  tic_top_state_t next_st;
  logic instr_en;
  logic [2:0] pin_eff;
  logic [2:0] cap;
  logic [2:0][15:0] cap_val;
  logic setup;
  logic wr;
  logic rd;
  logic [7:0] off;
  logic [2:0] clr;

  tic_divider u_div (
    .pclk(pclk),
    .presetn(presetn),
    .instr_en(instr_en)
  );

  // Pin selection and output loopback; an output-driven pin is captured like any input.
  always_comb begin
    pin_eff[0] = port_direction_bit[0] ? pin_primary[0] : port_out[0]; // see R8
    for (int i = 1; i < N; i++) begin
      if (st.pinsel[i-1]) begin // see R9
        pin_eff[i] = port_direction_bit[i] ? pin_primary[i] : port_out[i];
      end else begin
        pin_eff[i] = port_direction_bit[i] ? pin_alternate[i] : port_out[i];
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : gen_unit
      tic_pkg::tic_unit_cfg_t ucfg;
      tic_pkg::tic_unit_evt_t uevt;
      assign ucfg = {st.mode[g], st.mode_wr[g], st.tsel[g]}; // see R1
      tic_unit u_unit (
        .pclk(pclk),
        .presetn(presetn),
        .instr_en(instr_en),
        .cfg(ucfg),
        .pin(pin_eff[g]),
        .timers(timer_count),
        .evt(uevt)
      );
      assign cap[g] = uevt.capture;
      assign cap_val[g] = uevt.value;
    end
  endgenerate

  // Zero-wait APB: a transfer completes on the first access cycle.
  always_comb begin
    setup = psel && !penable;
    wr = setup && pwrite;
    rd = setup && !pwrite;
    off = paddr;
    clr = (wr && off == tic_pkg::REG_CLEAR) ? pwdata[2:0] : 3'h0;
    next_st = st;
    next_st.mode_wr = 3'h0;
    next_st.pready = setup;
    next_st.pslverr = 1'b0;
    next_st.prdata = 32'h0000_0000;
    if (wr) begin
      unique case (off)
        tic_pkg::REG_MODE: begin
          // Any mode write restarts the prescaler, so rewriting the same code resynchronises it.
          for (int i = 0; i < N; i++) begin
            next_st.mode_wr[i] = 1'b1; // see R13
            next_st.mode[i] = pwdata[4*i+:4];
          end
        end
        tic_pkg::REG_TSEL: next_st.tsel = pwdata[5:0];
        tic_pkg::REG_PINSEL: next_st.pinsel = pwdata[1:0];
        tic_pkg::REG_ENABLE: next_st.enable = pwdata[2:0];
        tic_pkg::REG_CLEAR: next_st.pslverr = 1'b0;
        default: next_st.pslverr = !(off inside {tic_pkg::REG_STATUS,
                                                 tic_pkg::REG_CAP0,
                                                 tic_pkg::REG_CAP0 + 8'h04,
                                                 tic_pkg::REG_CAP0 + 8'h08});
      endcase
    end
    if (rd) begin
      unique case (off)
        tic_pkg::REG_MODE: next_st.prdata = {20'h0, st.mode};
        tic_pkg::REG_TSEL: next_st.prdata = {26'h0, st.tsel};
        tic_pkg::REG_PINSEL: next_st.prdata = {30'h0, st.pinsel};
        tic_pkg::REG_STATUS: next_st.prdata = {29'h0, st.status};
        tic_pkg::REG_CLEAR: next_st.prdata = 32'h0000_0000;
        tic_pkg::REG_ENABLE: next_st.prdata = {29'h0, st.enable};
        tic_pkg::REG_CAP0: next_st.prdata = {16'h0, st.value[0]};
        tic_pkg::REG_CAP0 + 8'h04: next_st.prdata = {16'h0, st.value[1]};
        tic_pkg::REG_CAP0 + 8'h08: next_st.prdata = {16'h0, st.value[2]};
        default: next_st.pslverr = 1'b1;
      endcase
    end
    for (int i = 0; i < N; i++) begin
      if (cap[i]) begin
        next_st.value[i] = cap_val[i]; // see R6
      end
    end
    // A capture in the same cycle as a clear keeps the flag set.
    next_st.status = (st.status & ~clr) | cap; // see R4, R5
    next_st.irq = |(next_st.status & next_st.enable); // see R11
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.mode <= {N{tic_pkg::MODE_RST}};
      st.tsel <= {N{tic_pkg::TSEL_RST}};
      st.pinsel <= tic_pkg::PINSEL_RST;
    end else begin
      st <= next_st;
    end
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign irq = st.irq;

  property p_flag_set;
    @(posedge pclk) disable iff (!presetn)
      |cap |=> |st.status;
  endproperty
  a_flag_set: assert property (p_flag_set) // see R4
    else $error("capture did not set a flag");
  property p_flag_sticky;
    @(posedge pclk) disable iff (!presetn)
      (st.status[0] && !(wr && off == tic_pkg::REG_CLEAR && pwdata[0])) |=> st.status[0];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) // see R5
    else $error("flag cleared without software");
  property p_overwrite;
    @(posedge pclk) disable iff (!presetn)
      cap[0] |=> st.value[0] == $past(cap_val[0]);
  endproperty
  a_overwrite: assert property (p_overwrite) // see R6
    else $error("capture value not stored");
  property p_irq;
    @(posedge pclk) disable iff (!presetn)
      irq == |(st.status & st.enable);
  endproperty
  a_irq: assert property (p_irq) // see R11
    else $error("interrupt not matching flags");
  property p_pinsel_rst;
    @(posedge pclk)
      $rose(presetn) |-> st.pinsel == tic_pkg::PINSEL_RST;
  endproperty
  a_pinsel_rst: assert property (p_pinsel_rst) // see R9
    else $error("pin select reset values wrong");
  property p_apb_ready;
    @(posedge pclk) disable iff (!presetn)
      (psel && !penable) |=> pready ##1 !pready;
  endproperty
  a_apb_ready: assert property (p_apb_ready)
    else $error("apb answer timing wrong");

  c_cap: cover property (@(posedge pclk) disable iff (!presetn) cap[0]);
  c_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
  c_clr_set: cover property (@(posedge pclk) disable iff (!presetn) |(clr & cap));
endmodule

// ===== bench/tic_event_src.sv
// Event source model that drives the primary and alternate capture pins of all units.
`timescale 1ns/1ps
module tic_event_src (
  // Clock
  input wire logic pclk,
  // Capture pins
  output logic [2:0] pin_primary,
  output logic [2:0] pin_alternate
);
  logic [2:0] lvl = 3'h0;
  logic [2:0] alt_sel = 3'h4;
  logic [3:0] nz = 4'h0;

  always @(posedge pclk) begin
    nz <= nz + 4'h1;
  end

  // The pin that a unit should ignore keeps toggling, so a wrong pin choice shows up as captures.
  always_comb begin
    for (int u = 0; u < 3; u++) begin
      pin_primary[u] = alt_sel[u] ? nz[2] : lvl[u];
      pin_alternate[u] = alt_sel[u] ? lvl[u] : nz[2];
    end
  end

  // Each level is held long enough to cross the synchroniser and finish the capture.
  task automatic drive(input int u, input logic v);
    @(posedge pclk);
    lvl[u] <= v;
    repeat (12) @(posedge pclk);
  endtask
endmodule

// ===== bench/tic_capture_tb.sv
// Self-checking testbench of the input capture block.
`timescale 1ns/1ps
module tic_capture_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [47:0] timer_count = 48'hC3C3_B2B2_A1A1;
  logic [2:0] port_out = 3'h0;
  logic [2:0] port_direction_bit = 3'h7;
  logic [2:0] pin_primary;
  logic [2:0] pin_alternate;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic [31:0] rdv;
  logic errv;
  int miscompares = 0;
  int checks_done = 0;

  always #5 pclk = ~pclk;

  tic_capture tic_capture_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_count(timer_count), .pin_primary(pin_primary),
    .pin_alternate(pin_alternate), .port_out(port_out),
    .port_direction_bit(port_direction_bit), .irq(irq));

  tic_event_src tic_event_src_i (.pclk(pclk), .pin_primary(pin_primary),
    .pin_alternate(pin_alternate));

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      miscompares++;
      report_and_stop();
    end
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string msg);
    apb(1'b0, a, 32'h0);
    chk(rdv, exp, msg);
  endtask

  task automatic irq_is(input logic exp, input string msg);
    @(posedge pclk);
    #1;
    chk({31'h0, irq}, {31'h0, exp}, msg);
  endtask

  task automatic pulse(input int u, input int n);
    repeat (n) begin
      tic_event_src_i.drive(u, 1'b1);
      tic_event_src_i.drive(u, 1'b0);
    end
  endtask

  task automatic t_reset_values();
    rd(tic_pkg::REG_MODE, 32'h0, "mode reset");
    rd(tic_pkg::REG_TSEL, 32'h0, "timer select reset");
    rd(tic_pkg::REG_PINSEL, 32'h1, "pin select reset");
    rd(tic_pkg::REG_STATUS, 32'h0, "status reset");
    rd(tic_pkg::REG_ENABLE, 32'h0, "enable reset");
    apb(1'b0, 8'h18, 32'h0);
    chk({31'h0, errv}, 32'h1, "unmapped offset error");
    irq_is(1'b0, "irq after reset");
  endtask

  task automatic t_edges();
    apb(1'b1, tic_pkg::REG_MODE, {28'h0, tic_pkg::MODE_FALL});
    apb(1'b1, tic_pkg::REG_CLEAR, 32'h7);
    tic_event_src_i.drive(0, 1'b1);
    rd(tic_pkg::REG_STATUS, 32'h0, "rise ignored in fall mode");
    tic_event_src_i.drive(0, 1'b0);
    rd(tic_pkg::REG_STATUS, 32'h1, "fall captured");
    rd(tic_pkg::REG_CAP0, 32'hA1A1, "fall value");
    apb(1'b1, tic_pkg::REG_MODE, {28'h0, tic_pkg::MODE_RISE});
    apb(1'b1, tic_pkg::REG_CLEAR, 32'h7);
    tic_event_src_i.drive(0, 1'b1);
    rd(tic_pkg::REG_STATUS, 32'h1, "rise captured");
    apb(1'b1, tic_pkg::REG_CLEAR, 32'h7);
    tic_event_src_i.drive(0, 1'b0);
    rd(tic_pkg::REG_STATUS, 32'h0, "fall ignored in rise mode");
  endtask

  task automatic t_prescale();
    logic [3:0] codes [2] = '{tic_pkg::MODE_RISE4, tic_pkg::MODE_RISE16};
    int counts [2] = '{4, 16};
    // Two counted edges, then a rewrite of the same code must restart the count.
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, tic_pkg::REG_MODE, {28'h0, codes[i]});
      pulse(0, 2);
      apb(1'b1, tic_pkg::REG_MODE, {28'h0, codes[i]});
      apb(1'b1, tic_pkg::REG_CLEAR, 32'h7);
      pulse(0, counts[i] - 1);
      rd(tic_pkg::REG_STATUS, 32'h0, "prescaled edge too early");
      pulse(0, 1);
      rd(tic_pkg::REG_STATUS, 32'h1, "prescaled edge captured");
    end
  endtask

  task automatic t_timers_pins();
    apb(1'b1, tic_pkg::REG_TSEL, 32'h09);
    apb(1'b1, tic_pkg::REG_MODE, {20'h0, tic_pkg::MODE_RISE, tic_pkg::MODE_RISE,
      tic_pkg::MODE_RISE});
    apb(1'b1, tic_pkg::REG_CLEAR, 32'h7);
    pulse(0, 1);
    pulse(1, 1);
    pulse(2, 1);
    rd(tic_pkg::REG_STATUS, 32'h7, "all units captured");
    rd(tic_pkg::REG_CAP0, 32'hB2B2, "unit 0 on timer 1");
    rd(tic_pkg::REG_CAP0 + 8'h04, 32'hC3C3, "unit 1 on timer 2");
    rd(tic_pkg::REG_CAP0 + 8'h08, 32'hA1A1, "unit 2 on timer 0");
    apb(1'b1, tic_pkg::REG_PINSEL, 32'h2);
    tic_event_src_i.alt_sel <= 3'h2;
    timer_count <= 48'h3C3C_2B2B_1A1A;
    repeat (12) @(posedge pclk);
    apb(1'b1, tic_pkg::REG_CLEAR, 32'h7);
    rd(tic_pkg::REG_STATUS, 32'h0, "swapped pins quiet");
    pulse(1, 1);
    pulse(2, 1);
    rd(tic_pkg::REG_STATUS, 32'h6, "swapped pins captured");
    rd(tic_pkg::REG_CAP0 + 8'h04, 32'h3C3C, "unit 1 new pin");
    rd(tic_pkg::REG_CAP0 + 8'h08, 32'h1A1A, "unit 2 new pin");
  endtask

  task automatic t_irq_overwrite();
    apb(1'b1, tic_pkg::REG_MODE, {28'h0, tic_pkg::MODE_RISE});
    apb(1'b1, tic_pkg::REG_TSEL, 32'h0);
    apb(1'b1, tic_pkg::REG_CLEAR, 32'h7);
    apb(1'b1, tic_pkg::REG_ENABLE, 32'h1);
    pulse(0, 1);
    irq_is(1'b1, "irq on capture");
    timer_count <= 48'h0000_0000_5A5A;
    pulse(0, 1);
    rd(tic_pkg::REG_CAP0, 32'h5A5A, "unread value overwritten");
    apb(1'b1, tic_pkg::REG_STATUS, 32'h0);
    rd(tic_pkg::REG_STATUS, 32'h1, "flag stays after reads");
    apb(1'b1, tic_pkg::REG_ENABLE, 32'h0);
    irq_is(1'b0, "irq masked");
    apb(1'b1, tic_pkg::REG_ENABLE, 32'h1);
    irq_is(1'b1, "irq unmasked");
    apb(1'b1, tic_pkg::REG_CLEAR, 32'h1);
    rd(tic_pkg::REG_STATUS, 32'h0, "flag cleared");
    irq_is(1'b0, "irq after clear");
  endtask

  task automatic t_port_output();
    @(posedge pclk);
    port_direction_bit <= 3'h6;
    timer_count <= 48'h0000_0000_7E7E;
    apb(1'b1, tic_pkg::REG_CLEAR, 32'h7);
    port_out <= 3'h1;
    repeat (12) @(posedge pclk);
    rd(tic_pkg::REG_STATUS, 32'h1, "port write captured");
    rd(tic_pkg::REG_CAP0, 32'h7E7E, "port write value");
    port_direction_bit <= 3'h7;
  endtask

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_values();
    t_edges();
    t_prescale();
    t_timers_pins();
    t_irq_overwrite();
    t_port_output();
    report_and_stop();
  end

  initial begin
    repeat (100000) @(posedge pclk);
    miscompares++;
    report_and_stop();
  end
endmodule
